/* hw/tbo_top.sv */
// top: APB register file, buffered 16-bit timer access and crystal enable
`timescale 1ns/1ns

module tbo_top (
	input  wire logic        REF_CLK_I,
	input  wire logic        NRST_I,
	input  wire logic        PSEL_I,
	input  wire logic        PENABLE_I,
	input  wire logic        PWRITE_I,
	input  wire logic [13:0] PADDR_I,
	input  wire logic [31:0] PWDATA_I,
	input  wire logic [3:0]  PSTRB_I,
	output logic      [31:0] PRDATA_O,
	output logic             PREADY_O,
	output logic             PSLVERR_O,
	output logic             CRYSTAL_ENABLE_O,
	output logic      [15:0] TIMER_COUNT_O
);
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic [7:0]  first_ctrl_r;
	logic [7:0]  third_ctrl_r;
	logic [7:0]  main_osc_r;
	logic [7:0]  aux_osc_r;
	logic [7:0]  high_buf_r;
	logic [15:0] count;
	logic [2:0]  pre;
	logic        crystal_en;
	logic        access;
	logic        wr;
	logic        rd;
	logic        lane0;
	logic [11:0] idx;
	logic        mapped;
	logic        wide;
	logic        load;
	logic [15:0] load_val;
	logic [7:0]  rd_byte;

	// ----------------------------------------------------------------
	// apb decode: single-cycle access phase, pready high only in the cycle after setup
	// ----------------------------------------------------------------
	function automatic logic is_mapped(input logic [11:0] i);
		is_mapped = (i == tbo_pkg::IDX_AUX_OSC_CTRL) || (i == tbo_pkg::IDX_MAIN_OSC_CTRL)
			|| (i == tbo_pkg::IDX_TIMER_LOW) || (i == tbo_pkg::IDX_TIMER_HIGH)
			|| (i == tbo_pkg::IDX_FIRST_TIM_CTRL) || (i == tbo_pkg::IDX_THIRD_TIM_CTRL)
			|| (i == tbo_pkg::IDX_STATUS);
	endfunction

	assign idx    = PADDR_I[13:2];
	assign access = PSEL_I && PENABLE_I;
	assign mapped = is_mapped(idx) && (PADDR_I[1:0] == 2'h0);
	assign wr     = access && PWRITE_I && mapped;
	assign rd     = access && !PWRITE_I && mapped;
	// all registers are one byte wide; lane 0 carries the data
	assign lane0  = PSTRB_I[0];
	assign wide   = first_ctrl_r[tbo_pkg::BIT_WIDE_ACCESS];

	// ----------------------------------------------------------------
	// control registers
	// ----------------------------------------------------------------
	always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			first_ctrl_r <= tbo_pkg::RST_TIM_CTRL;
		end else if (wr && lane0 && idx == tbo_pkg::IDX_FIRST_TIM_CTRL) begin
			first_ctrl_r <= PWDATA_I[7:0] & tbo_pkg::MASK_TIM_CTRL_WR;
		end
	end

	always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			third_ctrl_r <= tbo_pkg::RST_TIM_CTRL;
		end else if (wr && lane0 && idx == tbo_pkg::IDX_THIRD_TIM_CTRL) begin
			third_ctrl_r <= PWDATA_I[7:0] & tbo_pkg::MASK_TIM_CTRL_WR;
		end
	end

	always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			main_osc_r <= tbo_pkg::RST_MAIN_OSC_CTRL;
		end else if (wr && lane0 && idx == tbo_pkg::IDX_MAIN_OSC_CTRL) begin
			main_osc_r <= PWDATA_I[7:0] & tbo_pkg::MASK_MAIN_OSC_WR;
		end
	end

	always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			aux_osc_r <= tbo_pkg::RST_AUX_OSC_CTRL;
		end else if (wr && lane0 && idx == tbo_pkg::IDX_AUX_OSC_CTRL) begin
			aux_osc_r <= PWDATA_I[7:0] & tbo_pkg::MASK_AUX_OSC_WR;
		end
	end

	// ----------------------------------------------------------------
	// high-byte buffer
	// ----------------------------------------------------------------
	always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			high_buf_r <= tbo_pkg::RST_BYTE;
		end else if (wide && rd && idx == tbo_pkg::IDX_TIMER_LOW) begin
			high_buf_r <= count[15:8];
		end else if (wide && wr && lane0 && idx == tbo_pkg::IDX_TIMER_HIGH) begin
			high_buf_r <= PWDATA_I[7:0];
		end
	end

	// ----------------------------------------------------------------
	// counter load path
	// ----------------------------------------------------------------
	always_comb begin
		load     = 1'b0;
		load_val = count;
		if (wr && lane0 && idx == tbo_pkg::IDX_TIMER_LOW) begin
			load     = 1'b1;
			// buffered: high byte comes only from the buffer
			load_val = {wide ? high_buf_r : count[15:8], PWDATA_I[7:0]};
		end else if (!wide && wr && lane0 && idx == tbo_pkg::IDX_TIMER_HIGH) begin
			load     = 1'b1;
			load_val = {PWDATA_I[7:0], count[7:0]};
		end
	end

	tbo_prescaler u_pre (
		.clk_i       (REF_CLK_I),
		.nrst_i      (NRST_I),
		.run_i       (first_ctrl_r[tbo_pkg::BIT_TIMER_ON]),
		.ratio_i     (first_ctrl_r[tbo_pkg::LSB_PRESCALE +: 2]),
		// only the low-byte write clears, high writes leave it alone
		.clear_pre_i (wr && lane0 && idx == tbo_pkg::IDX_TIMER_LOW),
		.load_i      (load),
		.load_val_i  (load_val),
		.count_o     (count),
		.pre_o       (pre)
	);

	// no start-up wait here; software times crystal settling itself
	tbo_crystal_enable u_xen (
		.clk_i       (REF_CLK_I),
		.nrst_i      (NRST_I),
		.first_en_i  (first_ctrl_r[tbo_pkg::BIT_CRYSTAL_EN]),
		.third_en_i  (third_ctrl_r[tbo_pkg::BIT_CRYSTAL_EN]),
		.warmup_i    (aux_osc_r[tbo_pkg::BIT_WARMUP_REQ]),
		.clock_sel_i (main_osc_r[tbo_pkg::LSB_CLOCK_SELECT +: 2]),
		.enable_o    (crystal_en)
	);

	// ----------------------------------------------------------------
	// read mux
	// ----------------------------------------------------------------
	always_comb begin
		rd_byte = 8'h00;
		unique case (idx)
			tbo_pkg::IDX_TIMER_LOW:      rd_byte = count[7:0];
			tbo_pkg::IDX_TIMER_HIGH:     rd_byte = wide ? high_buf_r : count[15:8];
			tbo_pkg::IDX_FIRST_TIM_CTRL: rd_byte = first_ctrl_r;
			tbo_pkg::IDX_THIRD_TIM_CTRL: rd_byte = third_ctrl_r;
			tbo_pkg::IDX_MAIN_OSC_CTRL:  rd_byte = main_osc_r;
			tbo_pkg::IDX_AUX_OSC_CTRL:
				rd_byte = aux_osc_r | (8'({crystal_en}) << tbo_pkg::BIT_CRYSTAL_RUN);
			tbo_pkg::IDX_STATUS:         rd_byte = {4'h0, crystal_en, pre};
			default:                     rd_byte = 8'h00;
		endcase
	end

	// ----------------------------------------------------------------
	// registered outputs
	// ----------------------------------------------------------------
	always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			PRDATA_O  <= 32'h00000000;
			PSLVERR_O <= 1'b0;
		end else begin
			PRDATA_O  <= (PSEL_I && !PENABLE_I && !PWRITE_I) ? {24'h000000, rd_byte} : PRDATA_O;
			PSLVERR_O <= PSEL_I && !PENABLE_I && !(is_mapped(idx) && PADDR_I[1:0] == 2'h0);
		end
	end

	always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			PREADY_O <= 1'b0;
		end else begin
			PREADY_O <= PSEL_I && !PENABLE_I;
		end
	end

	always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			CRYSTAL_ENABLE_O <= 1'b0;
			TIMER_COUNT_O    <= tbo_pkg::RST_COUNT;
		end else begin
			CRYSTAL_ENABLE_O <= crystal_en;
			TIMER_COUNT_O    <= count;
		end
	end
endmodule // tbo_top

/* hw/tbo_pkg.sv */
// package: register map, field positions and reset values of the timer/crystal block
package tbo_pkg;
	// ----------------------------------------------------------------
	// register indices (printed offsets are not word aligned)
	// ----------------------------------------------------------------
	localparam logic [11:0] IDX_AUX_OSC_CTRL   = 12'hfd2;
	localparam logic [11:0] IDX_MAIN_OSC_CTRL  = 12'hfd3;
	localparam logic [11:0] IDX_TIMER_LOW      = 12'hf00;
	localparam logic [11:0] IDX_TIMER_HIGH     = 12'hf01;
	localparam logic [11:0] IDX_FIRST_TIM_CTRL = 12'hf02;
	localparam logic [11:0] IDX_THIRD_TIM_CTRL = 12'hf03;
	localparam logic [11:0] IDX_STATUS         = 12'hf04;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int BIT_TIMER_ON       = 0;
	localparam int BIT_WIDE_ACCESS    = 1;
	localparam int BIT_CRYSTAL_EN     = 3;
	localparam int LSB_PRESCALE       = 4;
	localparam int BIT_WARMUP_REQ     = 3;
	localparam int BIT_CRYSTAL_RUN    = 6;
	localparam int LSB_CLOCK_SELECT   = 0;
	localparam int BIT_IDLE_ON_SLEEP  = 7;
	localparam logic [1:0] SEL_SECONDARY = 2'h1;

	// ----------------------------------------------------------------
	// reset values and writable masks
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_TIM_CTRL      = 8'h00;
	localparam logic [7:0] RST_MAIN_OSC_CTRL = 8'h00;
	localparam logic [7:0] RST_AUX_OSC_CTRL  = 8'h00;
	localparam logic [7:0] MASK_AUX_OSC_WR   = 8'h08;
	localparam logic [7:0] MASK_MAIN_OSC_WR  = 8'hf3;
	localparam logic [7:0] MASK_TIM_CTRL_WR  = 8'h3b;
	localparam logic [15:0] RST_COUNT        = 16'h0000;
	localparam logic [7:0] RST_BYTE          = 8'h00;
endpackage

/* hw/tbo_prescaler.sv */
// prescaler and 16-bit counter core for the timer
`timescale 1ns/1ns
module tbo_prescaler (
	input  wire logic        clk_i,
	input  wire logic        nrst_i,
	input  wire logic        run_i,
	input  wire logic [1:0]  ratio_i,
	input  wire logic        clear_pre_i,
	input  wire logic        load_i,
	input  wire logic [15:0] load_val_i,
	output logic      [15:0] count_o,
	output logic      [2:0]  pre_o
);
	logic [2:0] pre_r;
	logic       tick;

	// tick when the prescale count reaches 2^ratio - 1
	always_comb begin
		tick = run_i && ((pre_r & ((3'h1 << ratio_i) - 3'h1)) == ((3'h1 << ratio_i) - 3'h1));
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			pre_r <= 3'h0;
		end else if (clear_pre_i) begin
			pre_r <= 3'h0;
		end else if (run_i) begin
			pre_r <= tick ? 3'h0 : pre_r + 3'h1;
		end
	end

	// a load wins over a count in the same cycle
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			count_o <= tbo_pkg::RST_COUNT;
		end else if (load_i) begin
			count_o <= load_val_i;
		end else if (tick) begin
			count_o <= count_o + 16'h0001;
		end
	end

	assign pre_o = pre_r;
endmodule // tbo_prescaler

/* hw/tbo_crystal_enable.sv */
// enable logic for the secondary crystal oscillator
`timescale 1ns/1ns
module tbo_crystal_enable (
	input  wire logic       clk_i,
	input  wire logic       nrst_i,
	input  wire logic       first_en_i,
	input  wire logic       third_en_i,
	input  wire logic       warmup_i,
	input  wire logic [1:0] clock_sel_i,
	output logic            enable_o
);
	// no power-mode input at all: sleep and idle cannot gate it
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			enable_o <= 1'b0;
		end else begin
			enable_o <= first_en_i | third_en_i
				| warmup_i
				| (clock_sel_i == tbo_pkg::SEL_SECONDARY);
		end
	end
endmodule // tbo_crystal_enable

/* tb/tbo_top_assertions.sv */
// checker: bus timing and crystal-enable assertions for the timer block
`timescale 1ns/1ns
module tbo_top_assertions (
	input wire logic        REF_CLK_I,
	input wire logic        NRST_I,
	input wire logic        PSEL_I,
	input wire logic        PENABLE_I,
	input wire logic        PWRITE_I,
	input wire logic [13:0] PADDR_I,
	input wire logic [31:0] PWDATA_I,
	input wire logic [3:0]  PSTRB_I,
	input wire logic [31:0] PRDATA_O,
	input wire logic        PREADY_O,
	input wire logic        PSLVERR_O,
	input wire logic        CRYSTAL_ENABLE_O
);
	default clocking cb @(posedge REF_CLK_I); endclocking
	default disable iff (!NRST_I);
	sequence s_setup;
		PSEL_I && !PENABLE_I;
	endsequence
	sequence s_wr(logic [11:0] idx);
		PSEL_I && PENABLE_I && PREADY_O && PWRITE_I && PSTRB_I[0] && PADDR_I == {idx, 2'b00};
	endsequence
	a_ready_after_setup: assert property (s_setup |=> PREADY_O) else $error("no ready after setup");
	a_ready_one_pulse: assert property (PREADY_O |=> !PREADY_O) else $error("ready held too long");
	a_err_unaligned: assert property (s_setup ##0 PADDR_I[1:0] != 2'h0 |=> PSLVERR_O)
		else $error("unaligned access not refused");
	a_rdata_upper_zero: assert property (PREADY_O && !PWRITE_I |-> PRDATA_O[31:8] == 24'h0)
		else $error("read data upper bits set");
	a_crystal_from_timer: assert property (
		(s_wr(tbo_pkg::IDX_FIRST_TIM_CTRL) or s_wr(tbo_pkg::IDX_THIRD_TIM_CTRL)) ##0 PWDATA_I[3]
		|-> ##[1:4] CRYSTAL_ENABLE_O) else $error("timer bit did not start crystal");
	a_crystal_warmup: assert property (
		s_wr(tbo_pkg::IDX_AUX_OSC_CTRL) ##0 PWDATA_I[3] |-> ##[1:4] CRYSTAL_ENABLE_O)
		else $error("warm-up did not start crystal");
	a_crystal_select: assert property (
		s_wr(tbo_pkg::IDX_MAIN_OSC_CTRL) ##0 PWDATA_I[1:0] == 2'h1 |-> ##[1:4] CRYSTAL_ENABLE_O)
		else $error("clock select did not start crystal");
	// six idle cycles rule out a pending disable write
	a_crystal_holds: assert property (
		(!PSEL_I)[*6] ##0 $past(CRYSTAL_ENABLE_O, 3) |-> CRYSTAL_ENABLE_O)
		else $error("crystal dropped without a write");
endmodule // tbo_top_assertions

bind tbo_top tbo_top_assertions chk_u (.REF_CLK_I(REF_CLK_I), .NRST_I(NRST_I), .PSEL_I(PSEL_I),
	.PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PSTRB_I(PSTRB_I),
	.PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .CRYSTAL_ENABLE_O(CRYSTAL_ENABLE_O));

/* tb/tbo_top_tb.sv */
// testbench: register-bus checks of buffered timer access and crystal enable
`timescale 1ns/1ns
module tbo_top_tb;
	logic        clk;
	logic        nrst;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [13:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        xtal_en;
	logic [15:0] count;
	logic [31:0] rd;
	logic        er;
	int          err_count;
	int          n_checks;

	tbo_top dut_u (.REF_CLK_I(clk), .NRST_I(nrst), .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
		.PADDR_I(paddr), .PWDATA_I(pwdata), .PSTRB_I(4'hf), .PRDATA_O(prdata), .PREADY_O(pready),
		.PSLVERR_O(pslverr), .CRYSTAL_ENABLE_O(xtal_en), .TIMER_COUNT_O(count));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic final_report();
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// one transfer; request held until ready is sampled high
	task automatic xfer(input logic [13:0] a, input logic w, input logic [7:0] d);
		int n;
		@(posedge clk);
		psel   <= 1'b1;
		paddr  <= a;
		pwrite <= w;
		pwdata <= {24'h0, d};
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (pready !== 1'b1) begin
			err_count++;
			final_report();
		end else begin
			rd = prdata;
			er = pslverr;
			psel    <= 1'b0;
			penable <= 1'b0;
		end
	endtask

	task automatic wr(input logic [11:0] idx, input logic [7:0] d);
		xfer({idx, 2'b00}, 1'b1, d);
	endtask

	task automatic rdc(input logic [11:0] idx, input logic [7:0] exp);
		xfer({idx, 2'b00}, 1'b0, 8'h00);
		chk(rd, {24'h0, exp});
	endtask

	task automatic t_reset_map();
		rdc(tbo_pkg::IDX_AUX_OSC_CTRL, tbo_pkg::RST_AUX_OSC_CTRL);
		rdc(tbo_pkg::IDX_MAIN_OSC_CTRL, tbo_pkg::RST_MAIN_OSC_CTRL);
		rdc(tbo_pkg::IDX_FIRST_TIM_CTRL, tbo_pkg::RST_TIM_CTRL);
		rdc(tbo_pkg::IDX_THIRD_TIM_CTRL, tbo_pkg::RST_TIM_CTRL);
		rdc(12'h100, 8'h00);
		chk({31'h0, er}, 32'h1);
		xfer(14'h3c02, 1'b0, 8'h00);
		chk({31'h0, er}, 32'h1);
		$display("test reset_map done");
	endtask

	task automatic t_buffered();
		wr(tbo_pkg::IDX_FIRST_TIM_CTRL, 8'h00);
		wr(tbo_pkg::IDX_TIMER_HIGH, 8'ha5);
		rdc(tbo_pkg::IDX_TIMER_HIGH, 8'ha5);
		chk({16'h0, count}, 32'ha500);
		wr(tbo_pkg::IDX_FIRST_TIM_CTRL, 8'h02);
		wr(tbo_pkg::IDX_TIMER_HIGH, 8'h3c);
		repeat (2) @(posedge clk);
		chk({16'h0, count}, 32'ha500);
		wr(tbo_pkg::IDX_TIMER_LOW, 8'h11);
		repeat (2) @(posedge clk);
		chk({16'h0, count}, 32'h3c11);
		wr(tbo_pkg::IDX_TIMER_HIGH, 8'h99);
		rdc(tbo_pkg::IDX_TIMER_LOW, 8'h11);
		rdc(tbo_pkg::IDX_TIMER_HIGH, 8'h3c);
		wr(tbo_pkg::IDX_TIMER_HIGH, 8'h55);
		rdc(tbo_pkg::IDX_TIMER_HIGH, 8'h55);
		chk({16'h0, count}, 32'h3c11);
		$display("test buffered done");
	endtask

	task automatic t_prescaler();
		logic [7:0] p;
		wr(tbo_pkg::IDX_FIRST_TIM_CTRL, 8'h33);
		wr(tbo_pkg::IDX_FIRST_TIM_CTRL, 8'h32);
		xfer({tbo_pkg::IDX_STATUS, 2'b00}, 1'b0, 8'h00);
		p = rd[7:0] & 8'h07;
		chk({31'h0, p == 8'h00}, 32'h0);
		wr(tbo_pkg::IDX_TIMER_HIGH, 8'h01);
		wr(tbo_pkg::IDX_AUX_OSC_CTRL, 8'h00);
		rdc(tbo_pkg::IDX_STATUS, p);
		wr(tbo_pkg::IDX_TIMER_LOW, 8'h00);
		rdc(tbo_pkg::IDX_STATUS, 8'h00);
		$display("test prescaler done");
	endtask

	task automatic t_crystal();
		logic [11:0] idx [4];
		logic [7:0]  val [4];
		idx = '{tbo_pkg::IDX_FIRST_TIM_CTRL, tbo_pkg::IDX_THIRD_TIM_CTRL,
			tbo_pkg::IDX_AUX_OSC_CTRL, tbo_pkg::IDX_MAIN_OSC_CTRL};
		// idle select set too: crystal must not be gated
		val = '{8'h08, 8'h08, 8'h08, 8'h81};
		for (int i = 0; i < 4; i++) begin
			wr(idx[i], val[i]);
			repeat (8) @(posedge clk);
			chk({31'h0, xtal_en}, 32'h1);
			rdc(tbo_pkg::IDX_AUX_OSC_CTRL, (i == 2) ? 8'h48 : 8'h40);
			wr(idx[i], 8'h00);
			repeat (4) @(posedge clk);
			chk({31'h0, xtal_en}, 32'h0);
		end
		$display("test crystal done");
	endtask

	initial begin
		err_count = 0;
		n_checks = 0;
		nrst = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 14'h0;
		pwdata = 32'h0;
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
		t_reset_map();
		t_buffered();
		t_prescaler();
		t_crystal();
		final_report();
	end
endmodule // tbo_top_tb
